// ==== common/ais_pkg.sv ====
/*
 * Constants, types and tables for the converter input and reference select block.
 * Assumes a single 100 MHz clock and an asynchronous active-low reset.
 */
package ais_pkg;

    // ****************************************
    // Register map (indices, byte address = 4 x index)
    // ****************************************
    localparam logic [7:0] SEL_IDX    = 8'h07;
    localparam logic [7:0] CTLB_IDX   = 8'h03;
    localparam logic [7:0] DATA_IDX   = 8'h04;
    localparam logic [7:0] STAT_IDX   = 8'h08;
    localparam logic [7:0] SEL_RST    = 8'h00;
    localparam logic [7:0] CTLB_RST   = 8'h00;
    localparam int         SEL_LADJ   = 5;
    localparam int         CTLB_REFHI = 4;
    localparam int         CTLB_CHHI  = 3;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLV   = 2'h2;

    // ****************************************
    // Reference and channel codes
    // ****************************************
    localparam logic [1:0] REFLO_SUPPLY = 2'h0;
    localparam logic [1:0] REFLO_EXT    = 2'h1;
    localparam logic [2:0] REF_1V1      = 3'h2;
    localparam logic [2:0] REF_2V56     = 3'h6;
    localparam logic [2:0] REF_2V56_BYP = 3'h7;
    localparam logic [5:0] CH_SE_LAST   = 6'h0a;
    localparam logic [5:0] CH_DIFF_1ST  = 6'h0b;
    localparam logic [5:0] CH_DIFF_LAST = 6'h1d;
    localparam logic [5:0] CH_1V1       = 6'h1e;
    localparam logic [5:0] CH_0V        = 6'h1f;
    localparam logic [5:0] CH_TEMP      = 6'h3f;
    localparam logic [3:0] TEMP_INPUT   = 4'hb;

    // Differential pairs in code order: {positive, negative, gain 20x}
    localparam logic [8:0] DIFF_TAB [0:18] = '{
        9'h003, 9'h002, 9'h023, 9'h043, 9'h042, 9'h046, 9'h067, 9'h087, 9'h086,
        9'h08b, 9'h08a, 9'h0ab, 9'h0cb, 9'h0ca, 9'h113, 9'h112, 9'h133, 9'h153,
        9'h152};

    // ****************************************
    // Conversion length in converter clocks
    // ****************************************
    localparam logic [4:0] CONV_NORMAL = 5'd13;
    localparam logic [4:0] CONV_LONG   = 5'd25;

    typedef struct packed {
        logic supply;
        logic ext_pin;
        logic int_1v1;
        logic int_2v56;
        logic pin_bypass;
    } ais_ref_type;

    typedef struct packed {
        logic       single_en;
        logic [3:0] single_idx;
        logic       int_1v1;
        logic       zero_in;
        logic       temp_en;
        logic       diff_en;
        logic [3:0] pos;
        logic [3:0] neg;
        logic       gain20;
        logic       offset_meas;
    } ais_chan_type;

    function automatic logic [7:0] ais_byte_addr(input logic [7:0] idx);
        return {idx[5:0], 2'h0};
    endfunction

endpackage

// ==== design/ais_chan_decode.sv ====
/*
 * Registered decoder from the applied six-bit channel code to the analog switch controls.
 * Assumes the code is stable while a conversion runs.
 */
`timescale 1ns/1ps
module ais_chan_decode
    import ais_pkg::*;
(
    // Clock and reset
    input  wire logic         i_sys_clk,
    input  wire logic         i_arst_n,
    // Code in, switch controls out
    input  wire logic [5:0]   i_code,
    output ais_chan_type      o_chan
);

    ais_chan_type next_chan;
    logic [8:0]   entry;

    always_comb
    begin
        next_chan = '0;
        entry     = DIFF_TAB[5'(i_code - CH_DIFF_1ST)];
        if (i_code <= CH_SE_LAST)
        begin
            next_chan.single_en  = 1'b1;
            next_chan.single_idx = i_code[3:0];
        end
        else if (i_code <= CH_DIFF_LAST)
        begin
            next_chan.diff_en     = 1'b1;
            next_chan.pos         = entry[8:5];
            next_chan.neg         = entry[4:1];
            next_chan.gain20      = entry[0];
            next_chan.offset_meas = entry[8:5] == entry[4:1];
        end
        else if (i_code == CH_1V1)
        begin
            next_chan.int_1v1 = 1'b1;
        end
        else if (i_code == CH_0V)
        begin
            next_chan.zero_in = 1'b1;
        end
        else if (i_code == CH_TEMP)
        begin
            next_chan.single_en  = 1'b1;
            next_chan.single_idx = TEMP_INPUT;
            next_chan.temp_en    = 1'b1;
        end
        // Anything else stays all-off so a reserved code shorts nothing
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_chan <= '0;
        else
            o_chan <= next_chan;
    end

endmodule // ais_chan_decode

// ==== design/ais_top.sv ====
/*
 * Input and reference selection for a 10-bit converter, with AXI4-Lite register access,
 * selection shadowing across conversions and result presentation.
 * Assumes conversion start, done and result come from a sequencer on the same clock.
 */
`timescale 1ns/1ps
module ais_top
    import ais_pkg::*;
(
    // Clock and reset
    input  wire logic         i_sys_clk,
    input  wire logic         i_arst_n,
    // AXI4-Lite write channels
    input  wire logic [7:0]   i_awaddr,
    input  wire logic         i_awvalid,
    output logic              o_awready,
    input  wire logic [31:0]  i_wdata,
    input  wire logic [3:0]   i_wstrb,
    input  wire logic         i_wvalid,
    output logic              o_wready,
    output logic [1:0]        o_bresp,
    output logic              o_bvalid,
    input  wire logic         i_bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]   i_araddr,
    input  wire logic         i_arvalid,
    output logic              o_arready,
    output logic [31:0]       o_rdata,
    output logic [1:0]        o_rresp,
    output logic              o_rvalid,
    input  wire logic         i_rready,
    // Conversion sequencer
    input  wire logic         i_conv_start,
    input  wire logic         i_conv_done,
    input  wire logic [9:0]   i_result,
    // Analog path controls, conversion length and presented result
    output ais_ref_type       o_ref,
    output ais_chan_type      o_chan,
    output logic [4:0]        o_conv_cycles,
    output logic [15:0]       o_data
);

    // ****************************************
    // Registers and state
    // ****************************************
    logic [7:0] sel;
    logic [7:0] ctlb;
    logic       busy;
    logic       long_pending;
    logic       next_long_pending;
    logic [2:0] applied_ref;
    logic [5:0] applied_chan;
    logic [9:0] result;
    logic [2:0] cur_ref;
    logic [5:0] cur_chan;
    logic       wr_go;
    logic       rd_go;
    logic       wr_sel;
    logic       wr_ctlb;
    logic [2:0] wr_ref;
    logic [31:0] rd_mux;

    function automatic logic reg_hit(input logic [7:0] addr);
        return addr == ais_byte_addr(SEL_IDX) || addr == ais_byte_addr(CTLB_IDX)
            || addr == ais_byte_addr(DATA_IDX) || addr == ais_byte_addr(STAT_IDX);
    endfunction

    assign cur_ref  = {ctlb[CTLB_REFHI], sel[7:6]};
    assign cur_chan = {ctlb[CTLB_CHHI], sel[4:0]};

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    // Address and data are taken together; the handshake edge is the write edge.
    assign wr_go   = i_awvalid && i_wvalid && !o_awready && !o_bvalid;
    assign rd_go   = i_arvalid && !o_arready && !o_rvalid;
    assign wr_sel  = o_awready && i_wstrb[0] && i_awaddr == ais_byte_addr(SEL_IDX);
    assign wr_ctlb = o_awready && i_wstrb[0] && i_awaddr == ais_byte_addr(CTLB_IDX);
    assign wr_ref  = {wr_ctlb ? i_wdata[CTLB_REFHI] : ctlb[CTLB_REFHI],
                      wr_sel ? i_wdata[7:6] : sel[7:6]};

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= RESP_OKAY;
        end
        else
        begin
            o_awready <= wr_go;
            o_wready  <= wr_go;
            if (o_awready)
            begin
                o_bvalid <= 1'b1;
                o_bresp  <= reg_hit(i_awaddr) ? RESP_OKAY : RESP_SLV;
            end
            else if (i_bready)
                o_bvalid <= 1'b0;
        end
    end

    always_comb
    begin
        rd_mux = '0;
        if (i_araddr == ais_byte_addr(SEL_IDX))
            rd_mux[7:0] = sel;
        else if (i_araddr == ais_byte_addr(CTLB_IDX))
            rd_mux[7:0] = ctlb;
        else if (i_araddr == ais_byte_addr(DATA_IDX))
            rd_mux[15:0] = o_data;
        else if (i_araddr == ais_byte_addr(STAT_IDX))
            rd_mux[11:0] = {long_pending, busy, applied_ref, applied_chan[5:0], 1'b0};
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= '0;
            o_rresp   <= RESP_OKAY;
        end
        else
        begin
            o_arready <= rd_go;
            if (o_arready)
            begin
                o_rvalid <= 1'b1;
                o_rdata  <= rd_mux;
                o_rresp  <= reg_hit(i_araddr) ? RESP_OKAY : RESP_SLV;
            end
            else if (i_rready)
                o_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // Selection registers
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sel  <= SEL_RST;
            ctlb <= CTLB_RST;
        end
        else
        begin
            if (wr_sel)
                sel <= i_wdata[7:0];
            if (wr_ctlb)
            begin
                ctlb[CTLB_REFHI] <= i_wdata[CTLB_REFHI];
                ctlb[CTLB_CHHI]  <= i_wdata[CTLB_CHHI];
            end
        end
    end

    // ****************************************
    // Conversion tracking and shadows
    // ****************************************
    // A start in the same cycle as a done keeps the converter busy.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            busy <= 1'b0;
        else if (i_conv_start)
            busy <= 1'b1;
        else if (i_conv_done)
            busy <= 1'b0;
    end

    // Shadows follow the registers while idle and freeze from the start edge
    // until completion, so mid-conversion writes never disturb the analog path.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            applied_ref  <= '0;
            applied_chan <= '0;
        end
        else if (!busy || i_conv_done)
        begin
            applied_ref  <= cur_ref;
            applied_chan <= cur_chan;
        end
    end

    // A change request that lands with a start is kept for the following one.
    always_comb
    begin
        next_long_pending = long_pending;
        if (i_conv_start)
            next_long_pending = 1'b0;
        if ((wr_sel || wr_ctlb) && wr_ref != cur_ref)
            next_long_pending = 1'b1;
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            long_pending  <= 1'b0;
            o_conv_cycles <= CONV_NORMAL;
        end
        else
        begin
            long_pending  <= next_long_pending;
            o_conv_cycles <= next_long_pending ? CONV_LONG : CONV_NORMAL;
        end
    end

    // ****************************************
    // Reference decode
    // ****************************************
    // Reserved code 011 leaves every reference switch open.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_ref <= '0;
        else
        begin
            o_ref            <= '0;
            o_ref.supply     <= applied_ref[1:0] == REFLO_SUPPLY;
            o_ref.ext_pin    <= applied_ref[1:0] == REFLO_EXT;
            o_ref.int_1v1    <= applied_ref == REF_1V1;
            o_ref.int_2v56   <= applied_ref == REF_2V56 || applied_ref == REF_2V56_BYP;
            o_ref.pin_bypass <= applied_ref == REF_2V56_BYP;
        end
    end

    ais_chan_decode u_chan_decode (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_code    (applied_chan),
        .o_chan    (o_chan)
    );

    // ****************************************
    // Result presentation
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            result <= '0;
        else if (i_conv_done)
            result <= i_result;
    end

    // Follows the adjust bit every cycle, with no wait for a conversion.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_data <= '0;
        else if (sel[SEL_LADJ])
            o_data <= {result, 6'h00};
        else
            o_data <= {6'h00, result};
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);

    sel_write_a: assert property (wr_sel |=> sel == $past(i_wdata[7:0]))
        else $error("select register missed a write");
    ref_hold_a: assert property (busy && !i_conv_done |=> applied_ref == $past(applied_ref))
        else $error("reference shadow moved during conversion");
    chan_hold_a: assert property (busy && !i_conv_done |=> $stable(applied_chan))
        else $error("channel shadow moved during conversion");
    done_release_a: assert property (busy && i_conv_done |=> applied_chan == $past(cur_chan))
        else $error("shadow not released at completion");
    long_conv_a: assert property ((wr_sel || wr_ctlb) && wr_ref != cur_ref |=> o_conv_cycles == CONV_LONG [*1] ##0 long_pending)
        else $error("reference change did not lengthen next conversion");
    adjust_now_a: assert property (o_data == ($past(sel[SEL_LADJ]) ? {$past(result), 6'h00} : {6'h00, $past(result)}))
        else $error("data presentation does not follow adjust bit");
    ref_supply_a: assert property (applied_ref[1:0] == REFLO_SUPPLY |=> o_ref.supply && !o_ref.ext_pin && !o_ref.int_1v1)
        else $error("supply reference not selected");
    ref_bypass_a: assert property (applied_ref == REF_2V56_BYP |=> o_ref.int_2v56 && o_ref.pin_bypass)
        else $error("bypassed 2.56V reference not selected");
    temp_sel_a: assert property (applied_chan == CH_TEMP |=> o_chan.temp_en && o_chan.single_idx == TEMP_INPUT)
        else $error("temperature sensor not connected");
    offset_meas_a: assert property (o_chan.offset_meas |-> o_chan.diff_en && o_chan.pos == o_chan.neg)
        else $error("offset measurement on unequal pair");
    reserved_off_a: assert property (applied_chan > CH_0V && applied_chan != CH_TEMP |=> o_chan == '0)
        else $error("reserved channel code connected an input");

    // ****************************************
    // Handshake, register, decode, length, busy, shadow and result checks
    // ****************************************
    aw_pulse_a: assert property (o_awready |=> !o_awready)
        else $error("write address ready longer than one cycle");
    ready_pair_a: assert property (o_wready == o_awready)
        else $error("write data ready apart from address ready");
    write_resp_a: assert property (o_awready |=> o_bvalid)
        else $error("write response missing");
    bvalid_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("write response dropped before accepted");
    read_resp_a: assert property (o_arready |=> o_rvalid)
        else $error("read data missing");
    rvalid_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data changed before accepted");
    miss_wr_a: assert property (o_awready && !reg_hit(i_awaddr) |=> o_bresp == RESP_SLV)
        else $error("unmapped write not refused");
    miss_rd_a: assert property (o_arready && !reg_hit(i_araddr) |=> o_rresp == RESP_SLV)
        else $error("unmapped read not refused");
    ctl_wr_a: assert property (wr_ctlb |=> ctlb[CTLB_CHHI] == $past(i_wdata[CTLB_CHHI]))
        else $error("channel high bit missed a write");
    ref_ext_a: assert property (applied_ref[1:0] == REFLO_EXT |=> o_ref == 5'h08)
        else $error("external reference not selected alone");
    ref_1v1_a: assert property (applied_ref == REF_1V1 |=> o_ref == 5'h04)
        else $error("internal 1.1V reference not selected alone");
    ref_2v56_a: assert property (applied_ref == REF_2V56 |=> o_ref == 5'h02)
        else $error("unbypassed 2.56V reference not selected alone");
    ref_reserved_a: assert property (applied_ref == 3'h3 |=> o_ref == '0)
        else $error("reserved reference code closed a switch");
    conv_normal_a: assert property (i_conv_start && !(wr_sel || wr_ctlb)
        |=> o_conv_cycles == CONV_NORMAL)
        else $error("start did not restore normal length");
    busy_set_a: assert property (i_conv_start |=> busy)
        else $error("start did not mark converter busy");
    busy_clear_a: assert property (busy && i_conv_done && !i_conv_start |=> !busy)
        else $error("completion did not clear busy");
    idle_follow_a: assert property (!busy |=> applied_chan == $past(cur_chan))
        else $error("idle shadow did not follow register");
    right_adjust_a: assert property (!sel[SEL_LADJ] |=> o_data[15:10] == 6'h00)
        else $error("right adjusted data has upper bits set");
    result_load_a: assert property (i_conv_done |=> result == $past(i_result))
        else $error("result not captured at completion");
    single_sel_a: assert property (applied_chan <= CH_SE_LAST |=> o_chan.single_en)
        else $error("single-ended input not selected");
    chan_1v1_a: assert property (applied_chan == CH_1V1
        |=> o_chan.int_1v1 && !o_chan.single_en && !o_chan.diff_en)
        else $error("internal level not routed");
    chan_0v_a: assert property (applied_chan == CH_0V
        |=> o_chan.zero_in && !o_chan.single_en && !o_chan.diff_en)
        else $error("zero level not routed");
    diff_sel_a: assert property (applied_chan inside {[CH_DIFF_1ST:CH_DIFF_LAST]}
        |=> o_chan.diff_en && !o_chan.single_en)
        else $error("differential pair not selected");
    temp_only_a: assert property (o_chan.temp_en |-> o_chan.single_en)
        else $error("temperature sensor enabled without its input");

endmodule // ais_top

// ==== test/tb_ais_top.sv ====
/*
 * Self-checking bench for ais_top: register access over AXI4-Lite, reference and
 * channel decode, deferral across a conversion and result presentation.
 * Assumes ais_pkg is compiled first; the bench plays the conversion sequencer.
 */
`timescale 1ns/1ps
module tb_ais_top
    import ais_pkg::*;
;
    // ****************************************
    // Signals and constants
    // ****************************************
    logic         i_sys_clk, i_arst_n;
    logic [7:0]   i_awaddr, i_araddr;
    logic         i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [31:0]  i_wdata;
    logic [3:0]   i_wstrb;
    logic         o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]   o_bresp, o_rresp, r;
    logic [31:0]  o_rdata, d;
    logic         i_conv_start, i_conv_done;
    logic [9:0]   i_result;
    ais_ref_type  o_ref;
    ais_chan_type o_chan, e;
    logic [4:0]   o_conv_cycles;
    logic [15:0]  o_data;
    int           errors, check_count;

    localparam logic [7:0] A_SEL = SEL_IDX << 2;
    localparam logic [7:0] A_CTL = CTLB_IDX << 2;
    localparam logic [7:0] A_DAT = DATA_IDX << 2;
    localparam logic [7:0] A_STA = STAT_IDX << 2;
    localparam logic [7:0] A_BAD = 8'h40;
    // Differential pairs in code order: {positive, negative, unused, gain 20x}
    localparam logic [11:0] PAIRS [0:18] = '{
        12'h011, 12'h010, 12'h111, 12'h211, 12'h210, 12'h230, 12'h331, 12'h431,
        12'h430, 12'h451, 12'h450, 12'h551, 12'h651, 12'h650, 12'h891, 12'h890,
        12'h991, 12'ha91, 12'ha90};

    ais_top DUT (.i_sys_clk, .i_arst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
        .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
        .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_conv_start,
        .i_conv_done, .i_result, .o_ref, .o_chan, .o_conv_cycles, .o_data);

    // ****************************************
    // Expectations and bus tasks
    // ****************************************
    function automatic ais_ref_type exp_ref(input logic [2:0] c);
        if (c[1:0] == 2'h0)
            return 5'h10;
        if (c[1:0] == 2'h1)
            return 5'h08;
        if (c[2])
            return c[0] ? 5'h03 : 5'h02;
        return c[0] ? 5'h00 : 5'h04;
    endfunction

    function automatic ais_chan_type exp_chan(input logic [5:0] c);
        ais_chan_type x;
        logic [11:0]  t;
        x = '0;
        t = PAIRS[(c - 6'h0b) % 19];
        if (c <= 6'h0a)
        begin
            x.single_en  = 1'b1;
            x.single_idx = c[3:0];
        end
        else if (c <= 6'h1d)
        begin
            x.diff_en     = 1'b1;
            x.pos         = t[11:8];
            x.neg         = t[7:4];
            x.gain20      = t[0];
            x.offset_meas = (t[11:8] == t[7:4]);
        end
        else if (c == 6'h1e)
            x.int_1v1 = 1'b1;
        else if (c == 6'h1f)
            x.zero_in = 1'b1;
        else if (c == 6'h3f)
        begin
            x.single_en  = 1'b1;
            x.single_idx = 4'hb;
            x.temp_en    = 1'b1;
        end
        return x;
    endfunction

    task automatic check(input string n, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        @(posedge i_sys_clk);
        i_awaddr  <= a;
        i_wdata   <= {24'h0, v};
        i_wstrb   <= s;
        i_awvalid <= 1'b1;
        i_wvalid  <= 1'b1;
        i_bready  <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge i_sys_clk);
            if (o_awready === 1'b1 && !aw_ok)
            begin
                i_awvalid <= 1'b0;
                aw_ok = 1'b1;
            end
            if (o_wready === 1'b1 && !w_ok)
            begin
                i_wvalid <= 1'b0;
                w_ok = 1'b1;
            end
        end
        while (o_bvalid !== 1'b1) @(posedge i_sys_clk);
        r = o_bresp;
        i_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge i_sys_clk);
        i_araddr  <= a;
        i_arvalid <= 1'b1;
        i_rready  <= 1'b1;
        do @(posedge i_sys_clk); while (o_arready !== 1'b1);
        i_arvalid <= 1'b0;
        while (o_rvalid !== 1'b1) @(posedge i_sys_clk);
        d = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
    endtask

    // Reference high and channel high live in control_b, so both registers are written
    task automatic set_sel(input logic [2:0] rf, input logic la, input logic [5:0] ch);
        wr(A_CTL, {3'h0, rf[2], ch[5], 3'h0}, 4'hf);
        wr(A_SEL, {rf[1:0], la, ch[4:0]}, 4'hf);
        idle(3);
    endtask

    task automatic conv(input logic s, input logic dn, input logic [9:0] res);
        @(posedge i_sys_clk);
        i_conv_start <= s;
        i_conv_done  <= dn;
        i_result     <= res;
        @(posedge i_sys_clk);
        i_conv_start <= 1'b0;
        i_conv_done  <= 1'b0;
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ****************************************
    // Clock, watchdog and tests
    // ****************************************
    initial
    begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    // Whole run needs about 900 cycles
    initial
    begin
        idle(20000);
        $display("[FAIL] watchdog expected finish seen timeout");
        errors++;
        stop_test;
    end

    initial
    begin
        {i_arst_n, i_awaddr, i_awvalid, i_wdata, i_wstrb, i_wvalid, i_bready} = '0;
        {i_araddr, i_arvalid, i_rready, i_conv_start, i_conv_done, i_result} = '0;
        errors = 0;
        check_count = 0;
        idle(20);
        i_arst_n <= 1'b1;
        rd(A_SEL);
        check("select reset", 32'h0, d);
        check("select rd resp", 32'(RESP_OKAY), 32'(r));
        rd(A_CTL);
        check("control_b reset", 32'h0, d);
        wr(A_SEL, 8'hff, 4'hf);
        check("select wr resp", 32'(RESP_OKAY), 32'(r));
        rd(A_SEL);
        check("select rw", 32'hff, d);
        wr(A_SEL, 8'h00, 4'h0);
        rd(A_SEL);
        check("select strobe off", 32'hff, d);
        wr(A_BAD, 8'h5a, 4'hf);
        check("unmapped wr resp", 32'(RESP_SLV), 32'(r));
        rd(A_BAD);
        check("unmapped rd", {30'h0, RESP_SLV}, {d[29:0], r});
        $display("test registers finished");
        for (int c = 0; c < 8; c++)
        begin
            // Nothing drives the reference pin here, so internal codes are legal
            set_sel(3'(c), 1'b0, 6'h00);
            check("o_ref", 32'(exp_ref(3'(c))), 32'(o_ref));
        end
        $display("test reference finished");
        for (int c = 0; c < 64; c++)
        begin
            set_sel(3'h0, 1'b0, 6'(c));
            e = exp_chan(6'(c));
            if (c == 30 || c == 31)
                check("o_chan fixed", {e.int_1v1, e.zero_in, e.temp_en, e.diff_en},
                      {o_chan.int_1v1, o_chan.zero_in, o_chan.temp_en, o_chan.diff_en});
            else
                check("o_chan", 32'(e), 32'(o_chan));
        end
        $display("test channel finished");
        // Changes made while busy must not reach the analog path yet
        set_sel(3'h0, 1'b0, 6'h02);
        conv(1'b1, 1'b0, 10'h0);
        set_sel(3'h1, 1'b0, 6'h05);
        check("o_ref held", 32'(exp_ref(3'h0)), 32'(o_ref));
        check("o_chan held", 32'(exp_chan(6'h02)), 32'(o_chan));
        check("cycles long", 32'h19, 32'(o_conv_cycles));
        rd(A_STA);
        check("status busy", 32'h18, {27'h0, d[11:7]});
        conv(1'b0, 1'b1, 10'h2a5);
        idle(3);
        check("o_ref applied", 32'(exp_ref(3'h1)), 32'(o_ref));
        check("o_chan applied", 32'(exp_chan(6'h05)), 32'(o_chan));
        conv(1'b1, 1'b0, 10'h0);
        idle(2);
        check("cycles normal", 32'(CONV_NORMAL), 32'(o_conv_cycles));
        $display("test deferral finished");
        rd(A_DAT);
        check("data right", 32'h02a5, d);
        set_sel(3'h1, 1'b1, 6'h05);
        check("o_data left", 32'ha940, 32'(o_data));
        rd(A_DAT);
        check("data left", 32'ha940, d);
        conv(1'b0, 1'b1, 10'h155);
        idle(2);
        check("o_data new result", 32'h5540, 32'(o_data));
        $display("test adjust finished");
        stop_test;
    end
endmodule // tb_ais_top
